/* design/psp_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// register indices; byte address is four times the index
`define PSP_IDX_STATUS      8'h10
`define PSP_IDX_POWER       8'h11
`define PSP_IDX_IRQ_STAT    8'h14
`define PSP_IDX_IRQ_MASK    8'h15

// status word fields
`define PSP_ST_LINK         0
`define PSP_ST_SPEED10      1
`define PSP_ST_DUPLEX       2
`define PSP_ST_LOOPBACK     3
`define PSP_ST_NEG_DONE     4
`define PSP_ST_JABBER       5
`define PSP_ST_REM_FAULT    6
`define PSP_ST_INT_PEND     7
`define PSP_ST_PAGE_RX      8
`define PSP_STAT_RST        16'h0002

// power control word fields
`define PSP_PC_DIS_CLK      15
`define PSP_PC_PS_EN        14
`define PSP_PC_MODE_HI      13
`define PSP_PC_MODE_LO      12
`define PSP_MODE_NORMAL     2'h0
`define PSP_MODE_RSVD       2'h1
`define PSP_MODE_ACTIVE     2'h2
`define PSP_MODE_PASSIVE    2'h3

// interrupt status and mask bits
`define PSP_IRQ_PAGE_RX     0
`define PSP_IRQ_REM_FAULT   1
`define PSP_IRQ_LINK_CHG    2
`define PSP_IRQ_WAKE        3
`define PSP_IRQ_W           4

// axi responses
`define PSP_RESP_OKAY       2'h0
`define PSP_RESP_SLVERR     2'h2

// timing
`define PSP_CLK_HZ          125_000_000
`define PSP_NLP_PERIOD_MS   1400

`endif

/* design/psp_pkg.sv */
// types shared by the status and power control register bank
`default_nettype none
package psp_pkg;

  // whole state of the register bank
  typedef struct packed {
    logic        awReady;
    logic        wReady;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awIdx;
    logic [15:0] wData;
    logic [1:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [15:0] stat;
    logic        disClk;
    logic        psEn;
    logic [1:0]  psMode;
    logic [3:0]  irqStat;
    logic [3:0]  irqMask;
    logic        irq;
    logic        clkDisable;
    logic        sleepActive;
    logic        nlpPulse;
    logic [27:0] nlpCnt;
  } psp_state_t;

endpackage : psp_pkg

`default_nettype wire

/* design/psp_regs.sv */
// status word and power control word bank behind an axi4-lite slave
//
// Functional notes
// - page-received bit sets on new page, clears only on expansion read.
// - interrupt-pending bit latches high, clears on interrupt status read.
// - remote-fault bit sets on partner fault, clears on basic status read.
// - jabber bit copies basic jabber flag, only in 10 Mbps operation.
// - negotiation bit reads 1 once automatic negotiation has completed.
// - loopback bit reads 1 while interface loopback is enabled.
// - duplex bit reads 1 in full duplex, 0 in half duplex.
// - link bit copies basic link flag, unaffected by status reads.
// - disable-clock bit acts only while standard power-down is active.
// - mode field: 00 normal, 01 reserved, 10 active sleep; resets 00.
// - active sleep sends a link pulse every 1.4 seconds.
// - mode 11 is passive sleep: no link pulses, wakes on partner.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"

module psp_regs #(
  parameter int unsigned NLP_CYCLES =
    `PSP_NLP_PERIOD_MS * (`PSP_CLK_HZ / 1000) // pulse period in cycles
) (
  input  wire logic        clk_sys,      // system clock, 125 MHz
  input  wire logic        rst,          // async reset, active high
  input  wire logic        ce,           // clock enable, freezes state
  input  wire logic        awvalid,      // write address valid
  output logic             awready,      // write address ready
  input  wire logic [31:0] awaddr,       // write byte address
  input  wire logic        wvalid,       // write data valid
  output logic             wready,       // write data ready
  input  wire logic [31:0] wdata,        // write data
  input  wire logic [3:0]  wstrb,        // write byte strobes
  output logic             bvalid,       // write response valid
  input  wire logic        bready,       // write response ready
  output logic [1:0]       bresp,        // write response
  input  wire logic        arvalid,      // read address valid
  output logic             arready,      // read address ready
  input  wire logic [31:0] araddr,       // read byte address
  output logic             rvalid,       // read data valid
  input  wire logic        rready,       // read data ready
  output logic [31:0]      rdata,        // read data
  output logic [1:0]       rresp,        // read response
  input  wire logic        pageRxEvt,    // new code-word page received
  input  wire logic        expRead,      // expansion register was read
  input  wire logic        intPendIn,    // internal interrupt pending
  input  wire logic        intStatRead,  // interrupt status reg read
  input  wire logic        remFaultEvt,  // partner signalled remote fault
  input  wire logic        basicRead,    // basic status register read
  input  wire logic        jabberIn,     // basic status jabber flag
  input  wire logic        negDoneIn,    // negotiation complete
  input  wire logic        loopbackIn,   // interface loopback enabled
  input  wire logic        fullDupIn,    // full duplex operation
  input  wire logic        speed10In,    // 10 Mbps operation
  input  wire logic        linkIn,       // basic status link flag
  input  wire logic        pwrDownIn,    // standard power-down active
  input  wire logic        partnerIn,    // energy detect saw a partner
  output logic             clkDisable,   // shut internal clocks down
  output logic             sleepActive,  // sleep power-save in force
  output logic             nlpPulse,     // send one link pulse
  output logic             irq           // level interrupt, active high
);

  psp_pkg::psp_state_t q;
  psp_pkg::psp_state_t n;
  logic                wrGo;
  logic [15:0]         wMask;
  logic [7:0]          arIdx;
  logic                sleepMode;
  logic [3:0]          evts;

  ////////////////////////////////////////////////////////////////////////
  // next state

  // all register bank behaviour in one pass
  always_comb begin
    n         = q;
    wrGo      = q.awHeld && q.wHeld && !q.bValid;
    wMask     = {{8{q.wStrb[1]}}, {8{q.wStrb[0]}}};
    arIdx     = araddr[9:2];
    sleepMode = q.psEn && q.psMode[1];
    evts      = '0;

    // write address and data taken in either order
    if (awvalid && q.awReady) begin
      n.awHeld = 1'b1;
      n.awIdx  = awaddr[9:2];
    end
    if (wvalid && q.wReady) begin
      n.wHeld = 1'b1;
      n.wData = wdata[15:0];
      n.wStrb = wstrb[1:0];
    end
    if (bready && q.bValid) begin
      n.bValid = 1'b0;
    end

    n.stat[`PSP_ST_PAGE_RX] =
      (q.stat[`PSP_ST_PAGE_RX] & ~expRead) | pageRxEvt;
    n.stat[`PSP_ST_INT_PEND] =
      (q.stat[`PSP_ST_INT_PEND] & ~intStatRead) | intPendIn;
    n.stat[`PSP_ST_REM_FAULT] =
      (q.stat[`PSP_ST_REM_FAULT] & ~basicRead) | remFaultEvt;
    // jabber only meaningful at 10 Mbps
    n.stat[`PSP_ST_JABBER]   = jabberIn & speed10In;
    n.stat[`PSP_ST_NEG_DONE] = negDoneIn;
    n.stat[`PSP_ST_LOOPBACK] = loopbackIn;
    n.stat[`PSP_ST_DUPLEX]   = fullDupIn;
    n.stat[`PSP_ST_SPEED10]  = speed10In;
    n.stat[`PSP_ST_LINK]     = linkIn;

    // interrupt events
    evts[`PSP_IRQ_PAGE_RX]   = pageRxEvt;
    evts[`PSP_IRQ_REM_FAULT] = remFaultEvt;
    evts[`PSP_IRQ_LINK_CHG]  = linkIn != q.stat[`PSP_ST_LINK];

    // partner seen in sleep restores full power
    // passive sleep wakes the same way
    if (sleepMode && partnerIn) begin
      n.psEn                = 1'b0;
      n.psMode              = `PSP_MODE_NORMAL;
      evts[`PSP_IRQ_WAKE]   = 1'b1;
    end

    // register write, a power control write with the upper strobe overrides a wake
    if (wrGo) begin
      n.bValid = 1'b1;
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bResp  = `PSP_RESP_OKAY;
      case (q.awIdx)
        `PSP_IDX_STATUS: ;
        `PSP_IDX_POWER: begin
          if (q.wStrb[1]) begin
            n.disClk = q.wData[`PSP_PC_DIS_CLK];
            n.psEn   = q.wData[`PSP_PC_PS_EN];
            n.psMode = q.wData[`PSP_PC_MODE_HI:`PSP_PC_MODE_LO];
          end
        end
        `PSP_IDX_IRQ_STAT: begin
          n.irqStat = q.irqStat & ~(q.wData[3:0] & wMask[3:0]);
        end
        `PSP_IDX_IRQ_MASK: begin
          if (q.wStrb[0]) begin
            n.irqMask = q.wData[3:0];
          end
        end
        default: n.bResp = `PSP_RESP_SLVERR;
      endcase
    end
    // sticky events win over the write-one clear
    n.irqStat = n.irqStat | evts;
    n.awReady = !n.awHeld && !n.bValid;
    n.wReady  = !n.wHeld && !n.bValid;

    // read channel; reading the status word clears nothing
    if (rready && q.rValid) begin
      n.rValid = 1'b0;
    end
    if (arvalid && q.arReady) begin
      n.rValid = 1'b1;
      n.rResp  = `PSP_RESP_OKAY;
      n.rData  = '0;
      case (arIdx)
        `PSP_IDX_STATUS:   n.rData[15:0] = q.stat;
        `PSP_IDX_POWER:    n.rData[15:0] = {q.disClk, q.psEn, q.psMode,
                                            12'h000};
        `PSP_IDX_IRQ_STAT: n.rData[3:0]  = q.irqStat;
        `PSP_IDX_IRQ_MASK: n.rData[3:0]  = q.irqMask;
        default:           n.rResp       = `PSP_RESP_SLVERR;
      endcase
    end
    n.arReady = !n.rValid;

    // clock shutdown gated by standard power-down
    n.clkDisable  = n.disClk && pwrDownIn;
    // modes act only with the enable set
    // only codes 10 and 11 select a sleep
    n.sleepActive = n.psEn && n.psMode[1];

    // link pulse timer runs only in active sleep
    n.nlpPulse = 1'b0;
    if (n.sleepActive && n.psMode == `PSP_MODE_ACTIVE) begin
      if (q.nlpCnt == 28'(NLP_CYCLES - 1)) begin
        n.nlpCnt   = '0;
        n.nlpPulse = 1'b1;
      end else begin
        n.nlpCnt = q.nlpCnt + 28'h000_0001;
      end
    end else begin
      n.nlpCnt = '0;
    end

    n.irq = |(n.irqStat & n.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // one flop bank; clock enable freezes everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.stat <= `PSP_STAT_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  // outputs straight from the state flops
  assign awready     = q.awReady;
  assign wready      = q.wReady;
  assign bvalid      = q.bValid;
  assign bresp       = q.bResp;
  assign arready     = q.arReady;
  assign rvalid      = q.rValid;
  assign rdata       = q.rData;
  assign rresp       = q.rResp;
  assign clkDisable  = q.clkDisable;
  assign sleepActive = q.sleepActive;
  assign nlpPulse    = q.nlpPulse;
  assign irq         = q.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sRdTaken;
    ce && arvalid && arready;
  endsequence

  sequence sSleepWake;
    ce && sleepActive && q.psEn && partnerIn && !wrGo;
  endsequence

  sequence sWrPair;
    ce && q.awHeld && q.wHeld && !q.bValid;
  endsequence

  page_set_a: assert property (ce && pageRxEvt |=> q.stat[8])
    else $error("page bit not set");
  page_clr_a: assert property (
    ce && expRead && !pageRxEvt |=> !q.stat[8])
    else $error("page bit not cleared");
  int_pend_a: assert property (
    ce && intStatRead && !intPendIn |=> !q.stat[7])
    else $error("pending bit not cleared");
  int_set_a: assert property (
    ce && intPendIn |=> q.stat[`PSP_ST_INT_PEND])
    else $error("pending bit not set");
  rem_fault_a: assert property (
    ce && remFaultEvt |=> q.stat[6])
    else $error("remote fault not set");
  rem_clr_a: assert property (
    ce && basicRead && !remFaultEvt |=> !q.stat[`PSP_ST_REM_FAULT])
    else $error("remote fault not cleared");
  jabber_mask_a: assert property (
    ce && !speed10In |=> !q.stat[5])
    else $error("jabber at 100 Mbps");
  mirror_bits_a: assert property (
    ce |=> q.stat[4:0] == $past({negDoneIn, loopbackIn, fullDupIn,
                                  speed10In, linkIn}))
    else $error("status mirror wrong");
  clk_gate_a: assert property (
    ce && !pwrDownIn |=> !clkDisable)
    else $error("clock off outside power-down");
  clk_set_a: assert property (
    ce && pwrDownIn && q.disClk && !wrGo |=> clkDisable)
    else $error("clock not off in power-down");
  sleep_code_a: assert property (
    sleepActive |-> q.psMode[1] && q.psEn)
    else $error("sleep with wrong mode");
  nlp_mode_a: assert property (
    nlpPulse |-> q.psMode == `PSP_MODE_ACTIVE && sleepActive)
    else $error("link pulse outside active sleep");
  wake_a: assert property (sSleepWake |=> !q.psEn ##0 q.irqStat[3])
    else $error("no wake on partner");
  rd_answer_a: assert property (sRdTaken |=> rvalid && !arready)
    else $error("read not answered");
  wr_answer_a: assert property (sWrPair |=> bvalid && !awready && !wready)
    else $error("write not answered");

  // a low clock enable must hold every flop of the bank
  ce_freeze_a: assert property (!ce |=> $stable(q))
    else $error("state moved with clock enable low");

endmodule : psp_regs

`default_nettype wire

/* testbench/phy_status_power_ctrl_regs_tb_top.sv */
// self-checking bench for the status and power control register bank
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"
`define CHK(got, exp) begin \
  samplesChecked++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
  end \
end

module phy_status_power_ctrl_regs_tb_top;
  localparam int NLP = 20; // shortened link pulse period
  localparam logic [31:0] A_ST = {22'h0, `PSP_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_PC = {22'h0, `PSP_IDX_POWER, 2'b00};
  localparam logic [31:0] A_IS = {22'h0, `PSP_IDX_IRQ_STAT, 2'b00};
  localparam logic [31:0] A_IM = {22'h0, `PSP_IDX_IRQ_MASK, 2'b00};
  localparam logic [1:0]  OK   = `PSP_RESP_OKAY;
  logic        clk_sys, rst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pwrDownIn, partnerIn, clkDisable, sleepActive, nlpPulse, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb, strb;
  logic [1:0]  bresp, rresp, bExp;
  logic [5:0]  evt;      // page, exp rd, int pend, int rd, fault, basic rd
  logic [5:0]  lvl;      // link, speed10, duplex, loopback, neg, jabber
  int          errorCnt, samplesChecked, cycles, n;

  psp_regs #(.NLP_CYCLES(NLP)) u_psp_regs (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pageRxEvt(evt[0]), .expRead(evt[1]), .intPendIn(evt[2]),
    .intStatRead(evt[3]), .remFaultEvt(evt[4]), .basicRead(evt[5]),
    .linkIn(lvl[0]), .speed10In(lvl[1]), .fullDupIn(lvl[2]),
    .loopbackIn(lvl[3]), .negDoneIn(lvl[4]), .jabberIn(lvl[5]),
    .pwrDownIn(pwrDownIn), .partnerIn(partnerIn),
    .clkDisable(clkDisable), .sleepActive(sleepActive),
    .nlpPulse(nlpPulse), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      errorCnt++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite master tasks
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= strb;
    bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    `CHK(bresp, bExp)
    bready <= 1'b0;
  endtask : wr

  task automatic chkRd(input logic [31:0] a, input logic [31:0] expD,
                       input logic [1:0] expR);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    `CHK(rdata, expD)
    `CHK(rresp, expR)
    rready <= 1'b0;
  endtask : chkRd

  // one-cycle pulse on a sideband event input
  task automatic pulse(input int i);
    @(posedge clk_sys) evt[i] <= 1'b1;
    @(posedge clk_sys) evt[i] <= 1'b0;
  endtask : pulse

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  task automatic end_of_test();
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk_sys, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb, evt, pwrDownIn, partnerIn} = '0;
    {errorCnt, samplesChecked, cycles} = '0;
    strb = 4'hF;
    bExp = OK;
    rst = 1'b1;
    ce  = 1'b1;
    lvl = 6'h02;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(2);
    chkRd(A_ST, 32'h0000_0002, OK);
    chkRd(A_PC, 32'h0000_0000, OK);
    chkRd(32'h0000_0048, 32'h0000_0000, `PSP_RESP_SLVERR);
    // unmapped write answers with an error
    bExp = `PSP_RESP_SLVERR;
    wr(32'h0000_0048, 32'h0000_FFFF);
    bExp = OK;
    foreach (lvl[i]) begin
      lvl <= {i[0], i[1] ? 5'h1D : 5'h1F};
      cyc(2);
      repeat (2) chkRd(A_ST, {26'h0, i[0] & ~i[1], i[1] ? 5'h1D : 5'h1F},
                       OK);
    end
    lvl <= 6'h02;
    cyc(2);
    wr(A_ST, 32'h0000_FFFF);
    chkRd(A_ST, 32'h0000_0002, OK);
    // two link changes above left only the link change event
    chkRd(A_IS, 32'h0000_0004, OK);
    wr(A_IS, 32'h0000_000F);
    pulse(0);
    pulse(5);
    chkRd(A_ST, 32'h0000_0102, OK);
    pulse(1);
    chkRd(A_ST, 32'h0000_0002, OK);
    pulse(4);
    repeat (2) chkRd(A_ST, 32'h0000_0042, OK);
    pulse(5);
    chkRd(A_ST, 32'h0000_0002, OK);
    pulse(2);
    chkRd(A_ST, 32'h0000_0082, OK);
    pulse(3);
    chkRd(A_ST, 32'h0000_0002, OK);
    // clock enable low freezes the event latches
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    chkRd(A_ST, 32'h0000_0002, OK);
    // interrupt raise, mask and clear
    chkRd(A_IS, 32'h0000_0003, OK);
    `CHK(irq, 1'b0)
    wr(A_IM, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(A_IS, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b0)
    // partial strobes leave the other half alone
    strb = 4'h1;
    wr(A_PC, 32'h0000_C000);
    strb = 4'h2;
    wr(A_IM, 32'h0000_000F);
    strb = 4'hF;
    chkRd(A_PC, 32'h0000_0000, OK);
    chkRd(A_IM, 32'h0000_0001, OK);
    `CHK(irq, 1'b0)
    wr(A_PC, 32'h0000_8000);
    cyc(2);
    `CHK(clkDisable, 1'b0)
    pwrDownIn <= 1'b1;
    cyc(2);
    `CHK(clkDisable, 1'b1)
    chkRd(A_PC, 32'h0000_8000, OK);
    pwrDownIn <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(A_PC, 32'h0000_4000 | (m << 12));
      cyc(2);
      `CHK(sleepActive, m[1])
      chkRd(A_PC, 32'h0000_4000 | (m << 12), OK);
    end
    wr(A_PC, 32'h0000_2000);
    cyc(2);
    `CHK(sleepActive, 1'b0)
    wr(A_PC, 32'h0000_7000);
    n = 0;
    repeat (3 * NLP) @(posedge clk_sys) n += int'(nlpPulse !== 1'b0);
    `CHK(n, 0)
    wr(A_PC, 32'h0000_6000);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (nlpPulse !== 1'b1 && n < 4 * NLP);
    end
    `CHK(n, NLP)
    partnerIn <= 1'b1;
    cyc(2);
    `CHK(sleepActive, 1'b0)
    partnerIn <= 1'b0;
    chkRd(A_PC, 32'h0000_0000, OK);
    chkRd(A_IS, 32'h0000_000A, OK);
    end_of_test();
  end
endmodule : phy_status_power_ctrl_regs_tb_top
`default_nettype wire
